// ===== dioctl_pkg.sv
// Constants of the digital I/O and gate line controller.
// Assumes a single 100 MHz clock and an AXI4-Lite register port.
package dioctl_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] DIOCTL_CTRL_ADDR   = 8'h00;
  localparam logic [7:0] DIOCTL_VALUE_ADDR  = 8'h04;
  localparam logic [7:0] DIOCTL_CMD_ADDR    = 8'h08;
  localparam logic [7:0] DIOCTL_GROUP_ADDR  = 8'h0C;
  localparam logic [7:0] DIOCTL_STATUS_ADDR = 8'h10;

  // ****************************************************************
  // Control word fields
  // ****************************************************************
  localparam int DIOCTL_STATUS_BIT   = 0;
  localparam int DIOCTL_VALUE_BIT    = 1;
  localparam int DIOCTL_INVERT_BIT   = 2;
  localparam int DIOCTL_PUSHPULL_BIT = 3;
  localparam int DIOCTL_TRIG_LSB     = 4;
  localparam int DIOCTL_GATEMON_BIT  = 8;
  localparam int DIOCTL_RAISE_BIT    = 9;
  localparam int DIOCTL_DROP_BIT     = 10;
  localparam int DIOCTL_CLEAR_BIT    = 11;
  localparam int DIOCTL_CTRL_W       = 12;

  // Command word: start [3:0], stop [7:4], erase [11:8]
  localparam int DIOCTL_CMD_START_LSB = 0;
  localparam int DIOCTL_CMD_STOP_LSB  = 4;
  localparam int DIOCTL_CMD_ERASE_LSB = 8;

  // ****************************************************************
  // Reset values and widths
  // ****************************************************************
  localparam logic [11:0] DIOCTL_CTRL_RST  = 12'h000;
  localparam logic [7:0]  DIOCTL_VALUE_RST = 8'h00;
  localparam logic [7:0]  DIOCTL_GROUP_RST = 8'h00;
  localparam int          DIOCTL_NSYS      = 4;
  localparam int          DIOCTL_DIO_W     = 8;
  localparam logic [1:0]  DIOCTL_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  DIOCTL_RESP_SLVERR = 2'b10;

endpackage : dioctl_pkg

// ===== dioctl_sync.sv
// Two-stage synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to clk.
`timescale 1ns/1ps
module dioctl_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // Idle level of the pins is high
  always_comb begin
    meta_nxt = din;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      meta_r <= '1;
      sync_r <= '1;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign dout = sync_r;

endmodule : dioctl_sync

// ===== dioctl_top.sv
// Digital I/O port and gate line controller with AXI4-Lite registers.
// Assumes synchronous active-low reset and external pull-ups on pins.
//
// Contract
// - In status mode, pin n is high while system n acquires.
// - Invert reverses the level of status or value outputs.
// - In value mode the 8-bit programmable value drives the pins.
// - In value mode the value increments by one in each cycle in which a running system stops and no value write occurs.
// - A control bit picks push-pull or open-drain outputs.
// - With triggering on, input 4+n starts system n.
// - A start command then only arms monitoring of that input.
// - A falling trigger starts the system, clearing it first only with clear-before-start.
// - The system stops when the input returns, and rearms.
// - A stop command ends monitoring of the trigger input.
// - With clear-before-start, data are erased before start.
// - The gate line gates acquisition under three options.
// - With raise or gate monitoring on, drop-on-preset pulls the gate low at the sweep preset.
// - Modules group into up to four systems, one command each.
// - The control word holds each option as a single bit.
`timescale 1ns/1ps
module dioctl_top
  import dioctl_pkg::*;
#(
  parameter int NMOD = 4
) (
  input  wire logic                         clk,
  input  wire logic                         nrst,
  input  wire logic [7:0]                   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  input  wire logic [31:0]                  s_axi_wdata,
  input  wire logic [3:0]                   s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  input  wire logic [7:0]                   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  output logic [31:0]                       s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  input  wire logic [dioctl_pkg::DIOCTL_DIO_W-1:0] dioIn,
  output logic [dioctl_pkg::DIOCTL_DIO_W-1:0]      dioOut,
  output logic [dioctl_pkg::DIOCTL_DIO_W-1:0]      dioOe,
  input  wire logic [dioctl_pkg::DIOCTL_NSYS-1:0]  sweepPreset,
  input  wire logic                                gateIn,
  output logic                                     gateOut,
  output logic [NMOD-1:0]                          modRun,
  output logic [NMOD-1:0]                          modErase
);
  import dioctl_pkg::*;

  if (NMOD < 1 || NMOD > DIOCTL_NSYS) begin : g_bad_nmod
    $error("NMOD must lie in 1..4");
  end

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic [11:0] ctrl_r, ctrl_nxt;
  logic [7:0]  value_r, value_nxt;
  logic [7:0]  group_r, group_nxt;
  logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [7:0]  awAddr_r, awAddr_nxt;
  logic [31:0] wData_r, wData_nxt;
  logic [3:0]  wStrb_r, wStrb_nxt;
  logic        bValid_r, bValid_nxt;
  logic [1:0]  bResp_r, bResp_nxt;
  logic        rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0]  rResp_r, rResp_nxt;
  logic [3:0]  cmdStart, cmdStop, cmdErase;
  logic        doWrite;

  // ****************************************************************
  // System state
  // ****************************************************************
  typedef enum logic [1:0] {
    DIOCTL_IDLE  = 2'b00,
    DIOCTL_ARMED = 2'b01,
    DIOCTL_RUN   = 2'b11
  } dioctl_state_e;

  dioctl_state_e             sysSt_r [DIOCTL_NSYS];
  dioctl_state_e             sysSt_nxt [DIOCTL_NSYS];
  logic [DIOCTL_NSYS-1:0]    sysRun, sysClr;
  logic [DIOCTL_NSYS-1:0]    trigPrev_r, trigPrev_nxt;
  logic [DIOCTL_NSYS-1:0]    haltEv;
  logic [DIOCTL_DIO_W-1:0]   dioSync, gateSyncV;
  logic                      gate_r, gate_nxt;
  logic [DIOCTL_DIO_W-1:0]   dioOut_r, dioOut_nxt, dioOe_r, dioOe_nxt;
  logic [NMOD-1:0]           modRun_r, modRun_nxt, modErase_r, modErase_nxt;

  dioctl_sync #(.W(DIOCTL_DIO_W)) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (dioIn),
    .dout (dioSync)
  );

  dioctl_sync #(.W(DIOCTL_DIO_W)) u_gsync (
    .clk  (clk),
    .nrst (nrst),
    .din  ({{(DIOCTL_DIO_W-1){1'b1}}, gateIn}),
    .dout (gateSyncV)
  );

  // Byte-lane merge of a write into an old register value
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  always_comb begin
    logic [31:0] m;
    m = 32'h0000_0000;
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    awAddr_nxt = awAddr_r;
    wData_nxt  = wData_r;
    wStrb_nxt  = wStrb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    ctrl_nxt   = ctrl_r;
    value_nxt  = value_r;
    group_nxt  = group_r;
    cmdStart   = 4'h0;
    cmdStop    = 4'h0;
    cmdErase   = 4'h0;
    if (s_axi_awvalid && !awHeld_r) begin
      awHeld_nxt = 1'b1;
      awAddr_nxt = s_axi_awaddr;
    end
    if (s_axi_wvalid && !wHeld_r) begin
      wHeld_nxt = 1'b1;
      wData_nxt = s_axi_wdata;
      wStrb_nxt = s_axi_wstrb;
    end
    doWrite = awHeld_r && wHeld_r && !bValid_r;
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = DIOCTL_RESP_OKAY;
      unique case (awAddr_r)
        DIOCTL_CTRL_ADDR: begin
          m = merge({20'h00000, ctrl_r}, wData_r, wStrb_r);
          ctrl_nxt = m[DIOCTL_CTRL_W-1:0];
        end
        DIOCTL_VALUE_ADDR: begin
          m = merge({24'h000000, value_r}, wData_r, wStrb_r);
          value_nxt = m[7:0];
        end
        DIOCTL_GROUP_ADDR: begin
          m = merge({24'h000000, group_r}, wData_r, wStrb_r);
          group_nxt = m[7:0];
        end
        DIOCTL_CMD_ADDR: begin
          m = merge(32'h0000_0000, wData_r, wStrb_r);
          cmdStart = m[DIOCTL_CMD_START_LSB +: 4];
          cmdStop  = m[DIOCTL_CMD_STOP_LSB +: 4];
          cmdErase = m[DIOCTL_CMD_ERASE_LSB +: 4];
        end
        default: bResp_nxt = DIOCTL_RESP_SLVERR;
      endcase
    end
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rValid_r) begin
      rValid_nxt = 1'b1;
      rResp_nxt  = DIOCTL_RESP_OKAY;
      unique case (s_axi_araddr)
        DIOCTL_CTRL_ADDR:   rData_nxt = {20'h00000, ctrl_r};
        DIOCTL_VALUE_ADDR:  rData_nxt = {24'h000000, value_r};
        DIOCTL_GROUP_ADDR:  rData_nxt = {24'h000000, group_r};
        DIOCTL_CMD_ADDR:    rData_nxt = 32'h0000_0000;
        DIOCTL_STATUS_ADDR: rData_nxt = {23'h000000, gate_r,
                                         sysClr == 4'h0 ? 4'h0 : sysClr,
                                         sysRun};
        default: begin
          rData_nxt = 32'h0000_0000;
          rResp_nxt = DIOCTL_RESP_SLVERR;
        end
      endcase
    end else if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
    // Value register steps once per cycle when any running system stops; a write in the same cycle wins
    if (ctrl_r[DIOCTL_VALUE_BIT] && (haltEv != 4'h0) &&
        !(doWrite && awAddr_r == DIOCTL_VALUE_ADDR)) begin
      value_nxt = value_r + 8'h01;
    end
  end

  // ****************************************************************
  // Trigger-armed systems
  // ****************************************************************
  always_comb begin
    logic trig, fall, back, clrOpt;
    trig   = 1'b0;
    fall   = 1'b0;
    back   = 1'b0;
    clrOpt = ctrl_r[DIOCTL_CLEAR_BIT];
    trigPrev_nxt = trigPrev_r;
    haltEv = 4'h0;
    sysClr = 4'h0;
    for (int s = 0; s < DIOCTL_NSYS; s++) begin
      sysSt_nxt[s] = sysSt_r[s];
      // Inversion swaps which edge starts and which stops
      trig = dioSync[DIOCTL_TRIG_LSB + s] ^ ctrl_r[DIOCTL_INVERT_BIT];
      trigPrev_nxt[s] = trig;
      fall = trigPrev_r[s] && !trig;
      back = !trigPrev_r[s] && trig;
      if (cmdErase[s]) begin
        sysClr[s] = 1'b1;
      end
      if (cmdStop[s]) begin
        if (sysSt_r[s] == DIOCTL_RUN) haltEv[s] = 1'b1;
        sysSt_nxt[s] = DIOCTL_IDLE;
      end else if (cmdStart[s]) begin
        if (ctrl_r[DIOCTL_TRIG_LSB + s]) begin
          sysSt_nxt[s] = DIOCTL_ARMED;
        end else begin
          sysSt_nxt[s] = DIOCTL_RUN;
          sysClr[s] = 1'b1;
        end
      end else begin
        unique case (sysSt_r[s])
          DIOCTL_ARMED: if (fall) begin
            sysSt_nxt[s] = DIOCTL_RUN;
            sysClr[s] = 1'b1;
          end
          DIOCTL_RUN: begin
            if (ctrl_r[DIOCTL_TRIG_LSB + s] && back) begin
              sysSt_nxt[s] = DIOCTL_ARMED;
              haltEv[s] = 1'b1;
            end else if (sweepPreset[s]) begin
              sysSt_nxt[s] = DIOCTL_IDLE;
              haltEv[s] = 1'b1;
            end
          end
          DIOCTL_IDLE: ;
          default: sysSt_nxt[s] = DIOCTL_IDLE;
        endcase
      end
      sysRun[s] = (sysSt_r[s] == DIOCTL_RUN);
    end
    // Clear-before-trigger off: triggered starts keep old data
    if (!clrOpt) begin
      for (int s = 0; s < DIOCTL_NSYS; s++) begin
        if (sysSt_r[s] == DIOCTL_ARMED) sysClr[s] = cmdErase[s];
      end
    end
  end

  // ****************************************************************
  // Module grouping, gate line and pins
  // ****************************************************************
  always_comb begin
    logic [1:0] g;
    logic [DIOCTL_DIO_W-1:0] lvl;
    g = 2'b00;
    lvl = 8'h00;
    gate_nxt = gate_r;
    if (|(cmdStart | (sysClr & ~cmdErase)) &&
        ctrl_r[DIOCTL_RAISE_BIT]) begin
      gate_nxt = 1'b1;
    end
    if (ctrl_r[DIOCTL_DROP_BIT] && |sweepPreset) begin
      gate_nxt = 1'b0;
    end
    if (ctrl_r[DIOCTL_GATEMON_BIT]) begin
      gate_nxt = gate_nxt & gateSyncV[0];
    end else if (!ctrl_r[DIOCTL_RAISE_BIT]) begin
      gate_nxt = 1'b1;
    end
    // Run enables follow the gate value computed above
    for (int m = 0; m < NMOD; m++) begin
      g = group_r[2*m +: 2];
      modRun_nxt[m]   = sysRun[g] && gate_nxt;
      modErase_nxt[m] = sysClr[g];
    end
    if (ctrl_r[DIOCTL_VALUE_BIT]) begin
      lvl = value_nxt;
    end else if (ctrl_r[DIOCTL_STATUS_BIT]) begin
      lvl = {4'h0, sysRun};
    end
    lvl = lvl ^ {DIOCTL_DIO_W{ctrl_r[DIOCTL_INVERT_BIT]}};
    // Only lower pins drive in status mode; upper are trigger inputs
    dioOut_nxt = lvl;
    for (int b = 0; b < DIOCTL_DIO_W; b++) begin
      if (!ctrl_r[DIOCTL_VALUE_BIT] && !ctrl_r[DIOCTL_STATUS_BIT]) begin
        dioOe_nxt[b] = 1'b0;
      end else if (!ctrl_r[DIOCTL_VALUE_BIT] && b >= DIOCTL_TRIG_LSB) begin
        dioOe_nxt[b] = 1'b0;
      end else if (ctrl_r[DIOCTL_PUSHPULL_BIT]) begin
        dioOe_nxt[b] = 1'b1;
      end else begin
        dioOe_nxt[b] = !lvl[b];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctrl_r     <= DIOCTL_CTRL_RST;
      value_r    <= DIOCTL_VALUE_RST;
      group_r    <= DIOCTL_GROUP_RST;
      awHeld_r   <= 1'b0;
      wHeld_r    <= 1'b0;
      awAddr_r   <= 8'h00;
      wData_r    <= 32'h0000_0000;
      wStrb_r    <= 4'h0;
      bValid_r   <= 1'b0;
      bResp_r    <= 2'b00;
      rValid_r   <= 1'b0;
      rData_r    <= 32'h0000_0000;
      rResp_r    <= 2'b00;
      for (int s = 0; s < DIOCTL_NSYS; s++) sysSt_r[s] <= DIOCTL_IDLE;
      trigPrev_r <= 4'hF;
      gate_r     <= 1'b0;
      dioOut_r   <= 8'h00;
      dioOe_r    <= 8'h00;
      modRun_r   <= '0;
      modErase_r <= '0;
    end else begin
      ctrl_r     <= ctrl_nxt;
      value_r    <= value_nxt;
      group_r    <= group_nxt;
      awHeld_r   <= awHeld_nxt;
      wHeld_r    <= wHeld_nxt;
      awAddr_r   <= awAddr_nxt;
      wData_r    <= wData_nxt;
      wStrb_r    <= wStrb_nxt;
      bValid_r   <= bValid_nxt;
      bResp_r    <= bResp_nxt;
      rValid_r   <= rValid_nxt;
      rData_r    <= rData_nxt;
      rResp_r    <= rResp_nxt;
      sysSt_r    <= sysSt_nxt;
      trigPrev_r <= trigPrev_nxt;
      gate_r     <= gate_nxt;
      dioOut_r   <= dioOut_nxt;
      dioOe_r    <= dioOe_nxt;
      modRun_r   <= modRun_nxt;
      modErase_r <= modErase_nxt;
    end
  end

  assign s_axi_awready = !awHeld_r;
  assign s_axi_wready  = !wHeld_r;
  assign s_axi_bvalid  = bValid_r;
  assign s_axi_bresp   = bResp_r;
  assign s_axi_arready = !rValid_r;
  assign s_axi_rvalid  = rValid_r;
  assign s_axi_rdata   = rData_r;
  assign s_axi_rresp   = rResp_r;
  assign dioOut        = dioOut_r;
  assign dioOe         = dioOe_r;
  assign gateOut       = gate_r;
  assign modRun        = modRun_r;
  assign modErase      = modErase_r;

endmodule : dioctl_top

// ===== dioctl_monitor.sv
// Port checker for the digital I/O and gate line controller.
// Assumes binding to dioctl_top; sees nothing but its ports.
`timescale 1ns/1ps
module dioctl_monitor #(
  parameter int NMOD = 4
) (
  input wire logic            clk,
  input wire logic            nrst,
  input wire logic            s_axi_awvalid,
  input wire logic            s_axi_awready,
  input wire logic            s_axi_wvalid,
  input wire logic            s_axi_wready,
  input wire logic [1:0]      s_axi_bresp,
  input wire logic            s_axi_bvalid,
  input wire logic            s_axi_bready,
  input wire logic            s_axi_arvalid,
  input wire logic            s_axi_arready,
  input wire logic [31:0]     s_axi_rdata,
  input wire logic            s_axi_rvalid,
  input wire logic            s_axi_rready,
  input wire logic [7:0]      dioOut,
  input wire logic [7:0]      dioOe,
  input wire logic [3:0]      sweepPreset,
  input wire logic            gateOut,
  input wire logic [NMOD-1:0] modRun,
  input wire logic [NMOD-1:0] modErase
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sWrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence sWrAnswer;
    ##[1:2] s_axi_bvalid;
  endsequence

  a_reset_idle: assert property (
    $rose(nrst) |-> dioOut == 8'h00 && dioOe == 8'h00 && !gateOut
    && modRun == '0) else $error("outputs not idle after reset");
  a_erase_pulse: assert property (
    |modErase |=> modErase == '0) else $error("erase longer than a cycle");
  a_wr_answer: assert property (
    sWrTaken |-> sWrAnswer) else $error("write answer late");
  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_preset_stop: assert property (
    sweepPreset == 4'hF |-> ##[1:3] modRun == '0)
    else $error("run kept after preset");
  // Open drain may never drive a one, so any driven high is push-pull
  a_drive_high: assert property (
    (dioOe & dioOut) != 8'h00 |-> dioOe inside {8'h0F, 8'hFF})
    else $error("open drain drives high");
endmodule : dioctl_monitor

bind dioctl_top dioctl_monitor #(.NMOD(NMOD)) mon (
  .clk(clk), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dioOut(dioOut), .dioOe(dioOe),
  .sweepPreset(sweepPreset), .gateOut(gateOut), .modRun(modRun),
  .modErase(modErase)
);

// ===== dioctl_partner.sv
// External pins: pull-ups, open-collector trigger sources, gate line.
// Assumes the bench sets trigger levels between clock edges.
`timescale 1ns/1ps
module dioctl_partner (
  input  wire logic [7:0] dioOut,
  input  wire logic [7:0] dioOe,
  input  wire logic [3:0] trigLvl,
  input  wire logic       gateOut,
  output logic      [7:0] pinLvl,
  output logic            gateIn
);
  // ****************************************************************
  // Pin levels
  // ****************************************************************
  // Undriven pins float to the pull-up, never to the last level
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pinLvl[i] = dioOe[i] ? dioOut[i] : 1'b1;
      if (i >= 4 && !trigLvl[i[1:0]]) pinLvl[i] = 1'b0;
    end
  end
  assign gateIn = gateOut;
endmodule : dioctl_partner

// ===== dioctl_tb_top.sv
// Self-checking bench for the digital I/O and gate line controller.
// Assumes the package, the design and the partner model compile first.
`timescale 1ns/1ps
module dioctl_tb_top;
  import dioctl_pkg::*;
  logic        clk, nrst, awValid, wValid, bReady, arValid, rReady;
  logic        awReady, wReady, bValid, arReady, rValid, gateOut, gateIn;
  logic [7:0]  awAddr, arAddr, dioIn, dioOut, dioOe;
  logic [31:0] wData, rData;
  logic [1:0]  bResp, rResp;
  logic [3:0]  preset, trigLvl, modRun, modErase, seen;
  int          error_cnt, num_checks, cyc;

  dioctl_top #(.NMOD(4)) dut (
    .clk(clk), .nrst(nrst), .s_axi_awaddr(awAddr),
    .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
    .s_axi_rready(rReady), .dioIn(dioIn), .dioOut(dioOut),
    .dioOe(dioOe), .sweepPreset(preset), .gateIn(gateIn),
    .gateOut(gateOut), .modRun(modRun), .modErase(modErase)
  );
  dioctl_partner peer (
    .dioOut(dioOut), .dioOe(dioOe), .trigLvl(trigLvl),
    .gateOut(gateOut), .pinLvl(dioIn), .gateIn(gateIn)
  );

  // ****************************************************************
  // Tasks
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = DIOCTL_RESP_OKAY);
    @(posedge clk);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    do begin
      @(posedge clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
      if (bValid) begin
        bReady <= 1'b0;
        chk(32'(bResp), 32'(e));
      end
    end while (!bValid);
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] exp,
                     input logic [1:0] e = DIOCTL_RESP_OKAY);
    @(posedge clk);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    do begin
      @(posedge clk);
      if (arReady) arValid <= 1'b0;
      if (rValid) begin
        rReady <= 1'b0;
        chk(rData, exp);
        chk(32'(rResp), 32'(e));
      end
    end while (!rValid);
  endtask : axr

  // Bounded wait for a run pattern, gathering erase pulses meanwhile
  task automatic waitRun(input logic [3:0] e);
    seen = 4'h0;
    for (int n = 0; n < 30 && modRun !== e; n++) begin
      @(posedge clk);
      seen |= modErase;
    end
    chk(32'(modRun), 32'(e));
  endtask : waitRun

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle

  task automatic give_verdict;
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    {nrst, awValid, wValid, bReady, arValid, rReady} = '0;
    {awAddr, arAddr, wData, preset} = '0;
    trigLvl = 4'hF;
    {error_cnt, num_checks, cyc} = '0;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    axr(DIOCTL_CTRL_ADDR, 32'h0);
    axr(DIOCTL_VALUE_ADDR, 32'h0);
    axw(8'h20, 32'h1, DIOCTL_RESP_SLVERR);
    axr(8'h20, 32'h0, DIOCTL_RESP_SLVERR);
    axr(DIOCTL_CMD_ADDR, 32'h0);
    axw(DIOCTL_CMD_ADDR, 32'h001);
    waitRun(4'hF);
    axw(DIOCTL_CMD_ADDR, 32'h0F0);
    waitRun(4'h0);
    axw(DIOCTL_GROUP_ADDR, 32'hE4);
    axw(DIOCTL_CTRL_ADDR, 32'h009);
    axw(DIOCTL_CMD_ADDR, 32'h009);
    waitRun(4'h9);
    idle(3);
    chk(32'(dioOut[3:0]), 32'h9);
    chk(32'(dioOe), 32'h0F);
    axw(DIOCTL_CMD_ADDR, 32'h0F0);
    waitRun(4'h0);
    axw(DIOCTL_CTRL_ADDR, 32'h00D);
    axr(DIOCTL_CTRL_ADDR, 32'h00D);
    idle(3);
    chk(32'(dioOut[3:0]), 32'hF);
    // Top value wraps to zero at the stop
    axw(DIOCTL_VALUE_ADDR, 32'hFF);
    axw(DIOCTL_CTRL_ADDR, 32'h00A);
    idle(3);
    chk(32'(dioOut), 32'hFF);
    axw(DIOCTL_CMD_ADDR, 32'h001);
    waitRun(4'h1);
    axw(DIOCTL_CMD_ADDR, 32'h010);
    waitRun(4'h0);
    idle(3);
    chk(32'(dioOut), 32'h00);
    axw(DIOCTL_VALUE_ADDR, 32'h5A);
    axw(DIOCTL_CTRL_ADDR, 32'h00E);
    idle(3);
    chk(32'(dioOut), 32'hA5);
    axw(DIOCTL_CTRL_ADDR, 32'h002);
    idle(3);
    chk(32'(dioOe), 32'hA5);
    chk(32'(dioIn), 32'h5A);
    axw(DIOCTL_CTRL_ADDR, 32'h600);
    axw(DIOCTL_CMD_ADDR, 32'h001);
    waitRun(4'h1);
    chk(32'(gateOut), 32'h1);
    @(posedge clk) preset <= 4'hF;
    @(posedge clk) preset <= 4'h0;
    waitRun(4'h0);
    chk(32'(gateOut), 32'h0);
    axw(DIOCTL_CMD_ADDR, 32'h001);
    waitRun(4'h1);
    chk(32'(gateOut), 32'h1);
    axw(DIOCTL_CMD_ADDR, 32'h010);
    waitRun(4'h0);
    // Armed systems wait for their own trigger pin
    axw(DIOCTL_CTRL_ADDR, 32'h8F0);
    axw(DIOCTL_CMD_ADDR, 32'h00F);
    idle(10);
    chk(32'(modRun), 32'h0);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk) trigLvl[i] <= 1'b0;
      waitRun(4'(1 << i));
      chk(32'(seen), 32'(1 << i));
      @(posedge clk) trigLvl[i] <= 1'b1;
      waitRun(4'h0);
    end
    @(posedge clk) trigLvl[0] <= 1'b0;
    waitRun(4'h1);
    axw(DIOCTL_CMD_ADDR, 32'h0F0);
    @(posedge clk) trigLvl[0] <= 1'b1;
    @(posedge clk) trigLvl[0] <= 1'b0;
    idle(10);
    chk(32'(modRun), 32'h0);
    axr(DIOCTL_STATUS_ADDR, 32'h100);
    give_verdict();
  end
endmodule : dioctl_tb_top
